// File: hw/pts_defs.svh
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

// ====================================================================
// Register map
`define PTS_ADDR_W 12
`define PTS_OFF_CTRL 12'h000
`define PTS_OFF_CMD 12'h004
`define PTS_OFF_ROUTE 12'h008
`define PTS_OFF_CNT0_CFG 12'h00c
`define PTS_OFF_CNT1_CFG 12'h010
`define PTS_OFF_MON 12'h014
`define PTS_OFF_UI_LOAD 12'h018
`define PTS_OFF_CNT0_LOAD 12'h01c
`define PTS_OFF_CNT1_LOAD 12'h020
`define PTS_OFF_STATUS 12'h024
`define PTS_OFF_CNT0_VAL 12'h028
`define PTS_OFF_CNT1_VAL 12'h02c
`define PTS_OFF_CNT0_LATCH 12'h030
`define PTS_OFF_CNT1_LATCH 12'h034
`define PTS_CTRL_RST 11'h180

// ====================================================================
// Lines
`define PTS_LINES 10
`define PTS_SYNC_W 12
`define PTS_DIR_BASE 10
`define PTS_LINE_C1CLK 3
`define PTS_LINE_C1GATE 4
`define PTS_LINE_UPD 5
`define PTS_LINE_WF 6
`define PTS_LINE_C0CLK 8
`define PTS_LINE_C0GATE 9

// ====================================================================
// Timing
`define PTS_CLK_NS 8
`define PTS_CLK_KHZ 125000
`define PTS_TB_FAST_KHZ 20000
`define PTS_TB_SLOW_KHZ 100
`define PTS_ACC_W 18
`define PTS_SLOW_DIV (`PTS_CLK_KHZ / `PTS_TB_SLOW_KHZ)
`define PTS_SCAN_DLY_NS 50
`define PTS_SCAN_WID_NS 450
`define PTS_WF_WID_NS 25
`define PTS_UPD_WID_NS 50
`define PTS_STB_SLOW_NS 10000
`define PTS_STB_FAST_NS 1200
`define PTS_CYC_UP(ns) (((ns) + `PTS_CLK_NS - 1) / `PTS_CLK_NS)
`define PTS_SCAN_DLY_CYC `PTS_CYC_UP(`PTS_SCAN_DLY_NS)
`define PTS_SCAN_WID_CYC `PTS_CYC_UP(`PTS_SCAN_WID_NS)
`define PTS_WF_WID_CYC `PTS_CYC_UP(`PTS_WF_WID_NS)
`define PTS_UPD_WID_CYC `PTS_CYC_UP(`PTS_UPD_WID_NS)
`define PTS_STB_SLOW_HALF (`PTS_STB_SLOW_NS / (2 * `PTS_CLK_NS))
`define PTS_STB_FAST_HALF (`PTS_STB_FAST_NS / (2 * `PTS_CLK_NS))
`define PTS_STB_EDGES 16

`endif

// File: hw/pts_pkg.sv
package pts_pkg;

    typedef logic [3:0] pts_sel_t;
    typedef logic [15:0] pts_cnt_t;

    typedef struct packed {
        logic strobe_slow;
        logic strobe_hw;
        logic strobe_level;
        logic scan_rising;
        logic scan_en;
        logic posted_mode;
        logic sw_gate;
        logic update_ext;
        logic ui_src_ext;
        logic ui_src_low;
        logic ui_tb_slow;
    } pts_ctrl_t;

    typedef struct packed {
        logic [1:0] cnt_start;
        logic ui_stop;
        logic strobe_go;
    } pts_cmd_t;

    typedef struct packed {
        pts_sel_t wf_sel;
        logic wf_fall;
        pts_sel_t upd_sel;
        logic upd_fall;
        pts_sel_t uisrc_sel;
    } pts_route_t;

    typedef struct packed {
        pts_sel_t clk_sel;
        logic clk_fall;
        logic clk_ext;
        logic tb_slow;
        pts_sel_t gate_sel;
        logic gate_fall;
        logic out_toggle;
        logic out_low;
        logic dir_ext;
        logic dir_up;
    } pts_cnt_cfg_t;

    typedef struct packed {
        logic wf;
        logic upd;
        logic c0_clk;
        logic c0_gate;
        logic c1_clk;
        logic c1_gate;
        logic c0_out;
        logic c1_out;
    } pts_mon_t;

    typedef struct packed {
        pts_ctrl_t ctrl;
        pts_route_t route;
        pts_cnt_cfg_t [1:0] cfg;
        pts_mon_t mon;
        pts_cnt_t ui_load;
        pts_cnt_t [1:0] cnt_load;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] s3;
        logic [17:0] fast_acc;
        logic [10:0] slow_cnt;
        logic ui_run;
        pts_cnt_t ui_cnt;
        logic ui_src_prev;
        logic [5:0] scan_dly;
        logic [5:0] scan_wid;
        logic [5:0] wf_wid;
        logic [5:0] upd_wid;
        logic [10:0] stb_half;
        logic [4:0] stb_edges;
        logic stb_low;
        pts_cnt_t [1:0] cnt;
        logic [1:0] run;
        pts_cnt_t [1:0] latch;
        logic [1:0] tc_state;
        logic pready_q;
        logic pslverr_q;
        logic [31:0] prdata_q;
        logic [9:0] pfi_o;
        logic [9:0] pfi_e;
        logic dac_upd;
        logic wf_go;
        logic mark_q;
        logic stb_out_n;
        logic [1:0] c_out;
    } pts_state_t;

endpackage

// File: hw/pts_top.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "pts_defs.svh"

module pts_top
    import pts_pkg::*;
(
    input wire logic pclk, // Bus and core clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic [9:0] programmable_function_line_in, // Line levels
    output logic [9:0] programmable_function_line_out, // Monitor drive
    output logic [9:0] programmable_function_line_oe, // High while driving
    input wire logic digital_line_six, // Counter-0 direction
    input wire logic digital_line_seven, // Counter-1 direction
    input wire logic adc_convert_start, // Conversion start pulse
    input wire logic buffer_count_done, // Buffer counter expiry pulse
    output logic conversion_mark_pulse, // Scan-mark output level
    output logic conversion_mark_oe, // Scan-mark enable
    output logic external_latch_pulse_n, // Latch strobe, active low
    output logic waveform_start_trigger, // Waveform start pulse
    output logic dac_update, // DAC update pulse
    output logic counter0_output, // Counter-0 output level
    output logic counter0_output_oe, // Counter-0 output enable
    output logic counter1_output, // Counter-1 output level
    output logic counter1_output_oe // Counter-1 output enable
);

    pts_state_t st;
    pts_state_t n;

    // ====================================================================
    // Line selection
    function automatic logic pick_edge(logic [9:0] cur, logic [9:0] prev, pts_sel_t sel, logic fall);
        logic c;
        logic p;
        c = 1'b0;
        p = 1'b0;
        if (sel < 4'(`PTS_LINES)) begin
            c = cur[sel];
            p = prev[sel];
        end
        return fall ? (p & ~c) : (c & ~p);
    endfunction

    function automatic logic pick_level(logic [9:0] cur, pts_sel_t sel, logic inv);
        if (sel < 4'(`PTS_LINES)) begin
            return cur[sel] ^ inv;
        end
        return 1'b0;
    endfunction

    function automatic logic [32:0] read_reg(pts_state_t s, logic [11:0] a);
        logic hit;
        logic [31:0] d;
        hit = 1'b1;
        d = '0;
        case (a)
            `PTS_OFF_CTRL: d = 32'(s.ctrl);
            `PTS_OFF_CMD: d = '0;
            `PTS_OFF_ROUTE: d = 32'(s.route);
            `PTS_OFF_CNT0_CFG: d = 32'(s.cfg[0]);
            `PTS_OFF_CNT1_CFG: d = 32'(s.cfg[1]);
            `PTS_OFF_MON: d = 32'(s.mon);
            `PTS_OFF_UI_LOAD: d = 32'(s.ui_load);
            `PTS_OFF_CNT0_LOAD: d = 32'(s.cnt_load[0]);
            `PTS_OFF_CNT1_LOAD: d = 32'(s.cnt_load[1]);
            `PTS_OFF_STATUS: d = 32'({s.stb_edges != 5'h0, s.run, s.ui_run});
            `PTS_OFF_CNT0_VAL: d = 32'(s.cnt[0]);
            `PTS_OFF_CNT1_VAL: d = 32'(s.cnt[1]);
            `PTS_OFF_CNT0_LATCH: d = 32'(s.latch[0]);
            `PTS_OFF_CNT1_LATCH: d = 32'(s.latch[1]);
            default: hit = 1'b0;
        endcase
        return {hit, d};
    endfunction

    logic [9:0] lv;
    logic [9:0] lp;
    logic fast_tick;
    logic slow_tick;
    logic [17:0] acc_sum;
    logic wr;
    logic acc_first;
    pts_cmd_t cmd;
    logic [32:0] rd;
    logic wf_edge;
    logic ui_src_lvl;
    logic ui_tick;
    logic ui_event;
    logic upd_event;
    logic [1:0] c_tick;
    logic [1:0] c_gate_e;
    logic [1:0] c_up;
    logic [1:0] c_tc;
    logic [1:0] c_clk_mon;
    logic [1:0] c_gate_lvl;
    logic [10:0] stb_reload;

    // ====================================================================
    // Next-state logic
    always_comb begin
        n = st;
        lv = st.s2[9:0];
        lp = st.s3[9:0];
        fast_tick = 1'b0;
        slow_tick = 1'b0;
        cmd = '0;
        rd = read_reg(st, paddr);
        ui_tick = 1'b0;
        ui_event = 1'b0;
        c_tick = '0;
        c_gate_e = '0;
        c_up = '0;
        c_tc = '0;
        c_clk_mon = '0;
        c_gate_lvl = '0;
        n.dac_upd = 1'b0;
        n.wf_go = 1'b0;

        n.s1 = {digital_line_seven, digital_line_six, programmable_function_line_in};
        n.s2 = st.s1;
        n.s3 = st.s2;

        // Timebases as enable pulses
        acc_sum = st.fast_acc + 18'(`PTS_TB_FAST_KHZ);
        if (acc_sum >= 18'(`PTS_CLK_KHZ)) begin
            fast_tick = 1'b1;
            acc_sum = acc_sum - 18'(`PTS_CLK_KHZ);
        end
        n.fast_acc = acc_sum;
        if (st.slow_cnt == 11'(`PTS_SLOW_DIV - 1)) begin
            n.slow_cnt = '0;
            slow_tick = 1'b1;
        end else begin
            n.slow_cnt = st.slow_cnt + 11'h1;
        end

        // APB: one wait state, capture read data on first access cycle
        acc_first = psel & penable & ~st.pready_q;
        wr = psel & penable & st.pready_q & pwrite;
        n.pready_q = acc_first;
        if (acc_first) begin
            n.prdata_q = pwrite ? 32'h0000_0000 : rd[31:0];
            n.pslverr_q = ~rd[32];
        end
        if (wr & rd[32]) begin
            case (paddr)
                `PTS_OFF_CTRL: n.ctrl = pts_ctrl_t'(pwdata[$bits(pts_ctrl_t)-1:0]);
                `PTS_OFF_CMD: cmd = pts_cmd_t'(pwdata[$bits(pts_cmd_t)-1:0]);
                `PTS_OFF_ROUTE: n.route = pts_route_t'(pwdata[$bits(pts_route_t)-1:0]);
                `PTS_OFF_CNT0_CFG: n.cfg[0] = pts_cnt_cfg_t'(pwdata[$bits(pts_cnt_cfg_t)-1:0]);
                `PTS_OFF_CNT1_CFG: n.cfg[1] = pts_cnt_cfg_t'(pwdata[$bits(pts_cnt_cfg_t)-1:0]);
                `PTS_OFF_MON: n.mon = pts_mon_t'(pwdata[$bits(pts_mon_t)-1:0]);
                `PTS_OFF_UI_LOAD: n.ui_load = pwdata[15:0];
                `PTS_OFF_CNT0_LOAD: n.cnt_load[0] = pwdata[15:0];
                `PTS_OFF_CNT1_LOAD: n.cnt_load[1] = pwdata[15:0];
                default: n.ui_load = n.ui_load;
            endcase
        end

        // conversion start arms the mark delay
        if (adc_convert_start) begin
            n.scan_dly = 6'(`PTS_SCAN_DLY_CYC);
        end else if (st.scan_dly != 6'h0) begin
            n.scan_dly = st.scan_dly - 6'h1;
        end
        if (st.scan_dly == 6'h1) begin
            n.scan_wid = 6'(`PTS_SCAN_WID_CYC);
        end else if (st.scan_wid != 6'h0) begin
            n.scan_wid = st.scan_wid - 6'h1;
        end
        n.mark_q = n.ctrl.scan_en & ((n.scan_wid != 6'h0) ^ ~n.ctrl.scan_rising);

        stb_reload = st.ctrl.strobe_slow ? 11'(`PTS_STB_SLOW_HALF - 1) : 11'(`PTS_STB_FAST_HALF - 1);
        if (cmd.strobe_go & st.ctrl.strobe_hw & (st.stb_edges == 5'h0)) begin
            n.stb_edges = 5'(`PTS_STB_EDGES);
            n.stb_low = 1'b1;
            n.stb_half = stb_reload;
        end else if (st.stb_edges != 5'h0) begin
            if (st.stb_half == 11'h0) begin
                n.stb_half = stb_reload;
                n.stb_edges = st.stb_edges - 5'h1;
                n.stb_low = (st.stb_edges == 5'h1) ? 1'b0 : ~st.stb_low;
            end else begin
                n.stb_half = st.stb_half - 11'h1;
            end
        end
        n.stb_out_n = n.ctrl.strobe_hw ? ~n.stb_low : n.ctrl.strobe_level;

        wf_edge = pick_edge(lv, lp, st.route.wf_sel, st.route.wf_fall);
        n.wf_go = wf_edge;
        if (wf_edge) begin
            n.wf_wid = 6'(`PTS_WF_WID_CYC);
        end else if (st.wf_wid != 6'h0) begin
            n.wf_wid = st.wf_wid - 6'h1;
        end

        // interval clock from level input or timebase
        ui_src_lvl = pick_level(lv, st.route.uisrc_sel, st.ctrl.ui_src_low);
        n.ui_src_prev = ui_src_lvl;
        if (st.ctrl.ui_src_ext) begin
            ui_tick = ui_src_lvl & ~st.ui_src_prev;
        end else begin
            ui_tick = st.ctrl.ui_tb_slow ? slow_tick : fast_tick;
        end
        // interval counter start, stop and terminal event
        if (cmd.ui_stop | buffer_count_done) begin
            n.ui_run = 1'b0;
        end else if (wf_edge & ~st.ctrl.update_ext) begin
            n.ui_run = 1'b1;
            n.ui_cnt = st.ui_load;
        end else if (st.ui_run & ui_tick) begin
            if (st.ui_cnt == 16'h0000) begin
                ui_event = 1'b1;
                n.ui_cnt = st.ui_load;
            end else begin
                n.ui_cnt = st.ui_cnt - 16'h0001;
            end
        end

        // external update edge or internal event
        upd_event = st.ctrl.update_ext ? pick_edge(lv, lp, st.route.upd_sel, st.route.upd_fall) : ui_event;
        // software gate and posted mode qualify the update
        if (upd_event & st.ctrl.posted_mode & ~st.ctrl.sw_gate) begin
            // update issued on the next edge
            n.dac_upd = 1'b1;
            n.upd_wid = 6'(`PTS_UPD_WID_CYC);
        end else if (st.upd_wid != 6'h0) begin
            n.upd_wid = st.upd_wid - 6'h1;
        end

        // General-purpose counters
        for (int i = 0; i < 2; i++) begin
            // applied clock from line edge or timebase
            if (st.cfg[i].clk_ext) begin
                c_tick[i] = pick_edge(lv, lp, st.cfg[i].clk_sel, st.cfg[i].clk_fall);
                c_clk_mon[i] = pick_level(lv, st.cfg[i].clk_sel, st.cfg[i].clk_fall);
            end else begin
                c_tick[i] = st.cfg[i].tb_slow ? slow_tick : fast_tick;
                c_clk_mon[i] = c_tick[i];
            end
            c_gate_e[i] = pick_edge(lv, lp, st.cfg[i].gate_sel, st.cfg[i].gate_fall);
            c_gate_lvl[i] = pick_level(lv, st.cfg[i].gate_sel, st.cfg[i].gate_fall);
            c_up[i] = st.cfg[i].dir_ext ? st.s2[`PTS_DIR_BASE + i] : st.cfg[i].dir_up;
            c_tc[i] = c_up[i] ? (st.cnt[i] == 16'hffff) : (st.cnt[i] == 16'h0000);
            if (cmd.cnt_start[i]) begin
                n.cnt[i] = st.cnt_load[i];
                n.run[i] = 1'b1;
            end else begin
                // gate edge toggles run and latches count
                if (c_gate_e[i]) begin
                    n.run[i] = ~st.run[i];
                    n.latch[i] = st.cnt[i];
                end
                if (st.run[i] & c_tick[i]) begin
                    if (c_tc[i]) begin
                        n.cnt[i] = st.cnt_load[i];
                    end else if (c_up[i]) begin
                        n.cnt[i] = st.cnt[i] + 16'h0001;
                    end else begin
                        n.cnt[i] = st.cnt[i] - 16'h0001;
                    end
                end
            end
            // pulse or toggle on terminal count
            if (st.cfg[i].out_toggle) begin
                n.tc_state[i] = st.tc_state[i] ^ (st.run[i] & c_tick[i] & c_tc[i]);
            end else begin
                n.tc_state[i] = st.run[i] & c_tick[i] & c_tc[i];
            end
            n.c_out[i] = n.tc_state[i] ^ st.cfg[i].out_low;
        end

        n.pfi_o = '0;
        n.pfi_e = '0;
        n.pfi_o[`PTS_LINE_WF] = st.wf_wid != 6'h0;
        n.pfi_e[`PTS_LINE_WF] = st.mon.wf;
        n.pfi_o[`PTS_LINE_UPD] = st.upd_wid == 6'h0;
        n.pfi_e[`PTS_LINE_UPD] = st.mon.upd;
        n.pfi_o[`PTS_LINE_C0CLK] = c_clk_mon[0];
        n.pfi_e[`PTS_LINE_C0CLK] = st.mon.c0_clk;
        n.pfi_o[`PTS_LINE_C0GATE] = c_gate_lvl[0];
        n.pfi_e[`PTS_LINE_C0GATE] = st.mon.c0_gate;
        n.pfi_o[`PTS_LINE_C1CLK] = c_clk_mon[1];
        n.pfi_e[`PTS_LINE_C1CLK] = st.mon.c1_clk;
        n.pfi_o[`PTS_LINE_C1GATE] = c_gate_lvl[1];
        n.pfi_e[`PTS_LINE_C1GATE] = st.mon.c1_gate;
    end

    // ====================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl <= `PTS_CTRL_RST;
            st.stb_out_n <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // ====================================================================
    // Outputs
    assign pready = st.pready_q;
    assign prdata = st.prdata_q;
    assign pslverr = st.pslverr_q & st.pready_q;
    assign programmable_function_line_out = st.pfi_o;
    assign programmable_function_line_oe = st.pfi_e;
    assign conversion_mark_pulse = st.mark_q;
    assign conversion_mark_oe = st.ctrl.scan_en;
    assign external_latch_pulse_n = st.stb_out_n;
    assign waveform_start_trigger = st.wf_go;
    assign dac_update = st.dac_upd;
    assign counter0_output = st.c_out[0];
    assign counter0_output_oe = st.mon.c0_out;
    assign counter1_output = st.c_out[1];
    assign counter1_output_oe = st.mon.c1_out;

endmodule

// File: sim/pts_properties.sv
`timescale 1ns/1ns
module pts_properties (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [9:0] programmable_function_line_out, // Monitors
    input wire logic [9:0] programmable_function_line_oe, // Monitor enables
    input wire logic adc_convert_start, // Conversion start
    input wire logic conversion_mark_pulse, // Scan mark
    input wire logic waveform_start_trigger, // Trigger pulse
    input wire logic dac_update // Update pulse
);
    // ==========
    // Helpers
    wire [9:0] mo = programmable_function_line_out;
    logic [1:0] up;
    logic [5:0] since;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 2'h0;
            since <= 6'h3f;
        end else begin
            up <= {up[0], 1'b1};
            since <= adc_convert_start ? 6'h00 : (since == 6'h3f ? since : since + 6'h01);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_one_wait;
        ##1 !pready ##1 pready;
    endsequence
    sequence s_upd_low;
        !mo[5] [*7] ##1 mo[5];
    endsequence
    // ==========
    // Properties
    a_oe_startup: assert property (!$past(presetn) |-> programmable_function_line_oe == 10'h000)
        else $error("Monitor driven right after reset");
    a_apb_wait: assert property (psel && !penable |-> s_one_wait)
        else $error("Ready not after one wait state");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error without ready");
    a_mark_lead: assert property (up[1] && $rose(conversion_mark_pulse) |-> since inside {[6'd6:6'd12]})
        else $error("Scan mark delay out of range");
    a_mark_width: assert property (up[1] && $rose(conversion_mark_pulse) |-> conversion_mark_pulse [*8])
        else $error("Scan mark too short");
    a_trig_mon: assert property (waveform_start_trigger && programmable_function_line_oe[6] |-> ##[0:1] mo[6])
        else $error("Trigger not on its monitor");
    a_trig_width: assert property (up[1] && $rose(mo[6]) |-> mo[6] [*4] ##1 !mo[6])
        else $error("Trigger monitor width wrong");
    a_upd_mon: assert property (dac_update && programmable_function_line_oe[5] |-> ##[0:1] !mo[5])
        else $error("Update not on its monitor");
    a_upd_width: assert property (up[1] && $fell(mo[5]) |-> s_upd_low)
        else $error("Update monitor width wrong");
endmodule

bind pts_top pts_properties u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .programmable_function_line_out, .programmable_function_line_oe, .adc_convert_start,
    .conversion_mark_pulse, .waveform_start_trigger, .dac_update);

// File: sim/pts_line_model.sv
`timescale 1ns/1ns
module pts_line_model (
    input wire logic pclk, // Clock
    output logic [9:0] lines, // Function line levels
    output logic dir0, // Counter-0 direction
    output logic dir1 // Counter-1 direction
);
    initial begin
        lines = 10'h000;
        dir0 = 1'b0;
        dir1 = 1'b0;
    end
    // ==========
    // Pulse of w cycles, then a quiet gap
    // gap lets DAC latches reload
    task automatic pulse(input int n, input int w);
        lines[n] <= 1'b1;
        repeat (w) @(posedge pclk);
        lines[n] <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
endmodule

// File: sim/pts_top_tb.sv
`timescale 1ns/1ns
`include "pts_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pts_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, adc = 0, bdone = 0, stb_q = 1, err;
    logic pready, pslverr, stb_n, wf, upd, mark, mark_oe, c0, c0_oe, d0, d1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdata;
    logic [9:0] lines, lo, loe;
    logic [31:0] uc [3] = '{32'h0000_01e8, 32'h0000_01f8, 32'h0000_01c8};
    int ue [3] = '{1, 0, 0};
    int fail_count = 0, checks = 0, n_wf = 0, n_upd = 0, n_c0 = 0, n_stb = 0, n_lo = 0, i, n0, n1, w;
    always #4 pclk = ~pclk;
    pts_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .programmable_function_line_in(lines), .programmable_function_line_out(lo),
        .programmable_function_line_oe(loe), .digital_line_six(d0), .digital_line_seven(d1),
        .adc_convert_start(adc), .buffer_count_done(bdone), .conversion_mark_pulse(mark),
        .conversion_mark_oe(mark_oe), .external_latch_pulse_n(stb_n), .waveform_start_trigger(wf),
        .dac_update(upd), .counter0_output(c0), .counter0_output_oe(c0_oe), .counter1_output(),
        .counter1_output_oe());
    pts_line_model model (.pclk, .lines, .dir0(d0), .dir1(d1));
    // ==========
    // Event counters
    always @(posedge pclk) begin
        n_wf += (wf === 1'b1);
        n_upd += (upd === 1'b1);
        n_c0 += (c0 === 1'b1);
        n_lo += (stb_n === 1'b0);
        n_stb += (stb_q === 1'b1 && stb_n === 1'b0);
        stb_q = stb_n;
    end
    // ==========
    // Bus tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(n, e, rdata)
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        pause(40000);
        fail_count++;
        test_done();
    end
    // ==========
    // Tests
    initial begin
        pause(20);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("oe", 10'h000, loe)
        rd(`PTS_OFF_CTRL, 32'h0000_0180, "ctrl");
        rd(12'h040, 32'h0000_0000, "unmapped");
        `CHK("slverr", 1'b1, err)
        apb(1'b1, `PTS_OFF_MON, 32'h0000_00ff);
        `CHK("c0 oe", 1'b1, c0_oe)
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `PTS_OFF_ROUTE, i ? 32'h0000_0a2f : 32'h0000_082f);
            pause(8);
            n0 = n_wf;
            model.pulse(2, 4);
            `CHK("trigger", 1, n_wf - n0)
        end
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `PTS_OFF_CTRL, uc[i]);
            pause(8);
            n0 = n_upd;
            model.pulse(1, 4);
            `CHK("update", ue[i], n_upd - n0)
        end
        apb(1'b1, `PTS_OFF_UI_LOAD, 32'h0000_0003);
        apb(1'b1, `PTS_OFF_CTRL, 32'h0000_01e0);
        pause(8);
        n0 = n_upd;
        model.pulse(2, 4);
        pause(230);
        w = n_upd - n0;
        `CHK("interval", 1'b1, w >= 8 && w <= 11)
        bdone <= 1'b1;
        @(posedge pclk);
        bdone <= 1'b0;
        pause(10);
        n0 = n_upd;
        pause(100);
        `CHK("buffer stop", 0, n_upd - n0)
        model.pulse(2, 4);
        pause(50);
        apb(1'b1, `PTS_OFF_CMD, 32'h0000_0002);
        pause(10);
        n0 = n_upd;
        pause(100);
        `CHK("sw stop", 0, n_upd - n0)
        adc <= 1'b1;
        @(posedge pclk);
        adc <= 1'b0;
        w = 0;
        for (i = 0; i < 80; i++) begin
            @(posedge pclk);
            w += (mark === 1'b1);
        end
        `CHK("mark width", 57, w)
        `CHK("mark oe", 1'b1, mark_oe)
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `PTS_OFF_CTRL, i ? 32'h0000_07e0 : 32'h0000_03e0);
            n0 = n_stb;
            n1 = n_lo;
            apb(1'b1, `PTS_OFF_CMD, 32'h0000_0001);
            pause(i ? 10100 : 1300);
            `CHK("strobe pulses", 8, n_stb - n0)
            `CHK("strobe low", i ? 5000 : 600, n_lo - n1)
        end
        apb(1'b1, `PTS_OFF_CTRL, 32'h0000_00e0);
        pause(4);
        `CHK("strobe level", 1'b0, stb_n)
        model.dir1 <= 1'b1;
        apb(1'b1, `PTS_OFF_CNT0_LOAD, 32'h0000_0002);
        apb(1'b1, `PTS_OFF_CNT1_LOAD, 32'h0000_0005);
        apb(1'b1, `PTS_OFF_CNT0_CFG, 32'h0000_05e0);
        apb(1'b1, `PTS_OFF_CNT1_CFG, 32'h0000_0482);
        apb(1'b1, `PTS_OFF_CMD, 32'h0000_000c);
        n0 = n_c0;
        repeat (3) model.pulse(0, 3);
        rd(`PTS_OFF_CNT0_VAL, 32'h0000_0002, "cnt0");
        `CHK("c0 pulses", 1, n_c0 - n0)
        rd(`PTS_OFF_CNT1_VAL, 32'h0000_0008, "cnt1");
        model.pulse(4, 3);
        model.pulse(0, 3);
        rd(`PTS_OFF_CNT1_VAL, 32'h0000_0008, "cnt1 gated");
        rd(`PTS_OFF_CNT1_LATCH, 32'h0000_0008, "latch1");
        test_done();
    end
endmodule
